// [dv/scsp_monitor.sv]
/*
 * Bus checker for the serial command slave port.
 * Assumes a host sampled on CLK_IN and every frame addressed to the device.
 */
`timescale 1ns/100ps
module scsp_monitor (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	// Bus signals
	input wire logic scl,
	input wire logic sda,
	input wire logic host_scl_oe,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe
);
	logic       scl_r;
	logic       sda_r;
	logic       first_r;
	logic [3:0] bitn_r;
	wire        rise = scl && !scl_r;
	wire        start = scl && scl_r && sda_r && !sda;
	wire        stop = scl && scl_r && !sda_r && sda;

	always_ff @(posedge CLK_IN) begin
		scl_r <= scl;
		sda_r <= sda;
	end
	// Bit count in each byte since start, flag for the first byte
	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			bitn_r <= 4'h0;
			first_r <= 1'b0;
		end else if (start) begin
			bitn_r <= 4'h0;
			first_r <= 1'b1;
		end else if (rise) begin
			bitn_r <= (bitn_r == 4'h8) ? 4'h0 : bitn_r + 4'h1;
			first_r <= first_r && (bitn_r != 4'h8);
		end
	end

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RESETN_IN);

	property p_dev_stable; scl && scl_r |-> $stable(dev_sda_oe); endproperty
	a_dev_stable: assert property (p_dev_stable)
		else $error("device data moved while clock high");
	property p_ack_addr;
		rise && first_r && bitn_r == 4'h8 |-> (dev_sda_oe && !sda) [*8];
	endproperty
	a_ack_addr: assert property (p_ack_addr)
		else $error("no address acknowledge on ninth pulse");
	property p_addr_quiet; rise && first_r && bitn_r < 4'h8 |-> !dev_sda_oe;
	endproperty
	a_addr_quiet: assert property (p_addr_quiet)
		else $error("device drove data during address bits");
	property p_host_free; rise && first_r && bitn_r == 4'h8 |-> !host_sda_oe;
	endproperty
	a_host_free: assert property (p_host_free)
		else $error("host held data in acknowledge slot");
	property p_stop_rel; stop |-> !dev_sda_oe [*8]; endproperty
	a_stop_rel: assert property (p_stop_rel)
		else $error("device held data after stop");
	property p_start_host; start |-> host_sda_oe && !dev_sda_oe; endproperty
	a_start_host: assert property (p_start_host)
		else $error("start not made by host");
	property p_scl_high; rise |-> scl [*8]; endproperty
	a_scl_high: assert property (p_scl_high)
		else $error("clock high too short");
	property p_scl_low; !scl && scl_r |-> !scl [*8]; endproperty
	a_scl_low: assert property (p_scl_low)
		else $error("clock low too short");

	c_start: cover property (start);
	c_ack: cover property (rise && first_r && bitn_r == 4'h8);
	c_stop: cover property (stop);
endmodule : scsp_monitor

// [dv/serial_command_slave_port_tb.sv]
/*
 * Testbench: host and device joined by the bus, all operation kinds.
 * Assumes the device user answers reads with {code^5a, code}.
 */
`timescale 1ns/100ps
module serial_command_slave_port_tb;
	import scsp_pkg::*;
	logic clk = 0, lclk = 0, rstn = 0, lrstn = 0, rail = 0, vld = 0;
	scsp_op_type op = OP_SEND;
	logic [7:0] code = 8'h00;
	logic [15:0] data = 16'h0000, rd = 16'h0000, wrd, hrd;
	logic [7:0] cmd;
	logic [1:0] wcnt;
	logic rdy, done, aerr, pset, wstb, clr;
	int bad_count = 0, checks = 0, ptr_n = 0, wr_n = 0, clr_n = 0;

	always #2 clk = ~clk;
	initial #3 forever #16 lclk = ~lclk;
	scsp_bus_if bus();
	scsp_host #(.SCL_QTR(80), .SUPPLY_WAIT(20)) scsp_host_i (
		.CLK_IN(clk), .RESETN_IN(rstn), .MAIN_SUPPLY_RAIL_OK_IN(rail),
		.CMD_VALID_IN(vld), .CMD_OP_IN(op), .CMD_CODE_IN(code),
		.CMD_DATA_IN(data), .CMD_READY_OUT(rdy), .DONE_OUT(done),
		.ACK_ERR_OUT(aerr), .RD_DATA_OUT(hrd), .BUS(bus.host));
	scsp_device scsp_device_i (
		.CLK_IN(clk), .RESETN_IN(rstn), .LINK_CLK_IN(lclk),
		.LINK_RESETN_IN(lrstn), .CMD_OUT(cmd), .PTR_SET_OUT(pset),
		.WR_STB_OUT(wstb), .WR_DATA_OUT(wrd), .WR_COUNT_OUT(wcnt),
		.CLR_FAULT_OUT(clr), .RD_DATA_IN(rd), .BUS(bus.dev));
	scsp_monitor scsp_monitor_i (
		.CLK_IN(clk), .RESETN_IN(rstn), .scl(bus.scl), .sda(bus.sda),
		.host_scl_oe(bus.host_scl_oe), .host_sda_oe(bus.host_sda_oe),
		.dev_sda_oe(bus.dev_sda_oe));

	// ------------------------------------------------------------------
	// Device user side
	// ------------------------------------------------------------------
	always @(posedge clk) begin
		rd <= {cmd ^ 8'h5a, cmd};
		ptr_n <= ptr_n + int'(pset);
		wr_n <= wr_n + int'(wstb);
		clr_n <= clr_n + int'(clr);
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task finish_test;
		if (bad_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	task run(input scsp_op_type o, input logic [7:0] c, input logic [15:0] d);
		int n;
		n = 0;
		do begin @(posedge clk); #1; n++; end while (rdy !== 1'b1 && n < 9000);
		if (n >= 9000) bad_count++;
		@(posedge clk);
		vld <= 1'b1;
		op <= o;
		code <= c;
		data <= d;
		@(posedge clk);
		vld <= 1'b0;
		n = 0;
		do begin @(posedge clk); #1; n++; end while (done !== 1'b1 && n < 20000);
		if (n >= 20000) bad_count++;
		repeat (60) @(posedge clk);
		check(16'(aerr), 16'h0000);
		check(16'(cmd), 16'(c));
	endtask : run

	// ------------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (5) @(posedge lclk);
		lrstn <= 1'b1;
	end
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (60) @(posedge clk);
		check(16'(rdy), 16'h0000);
		rail <= 1'b1;
		repeat (20) @(posedge clk);
		check(16'(rdy), 16'h0000);
		run(OP_SEND, 8'h03, 16'h0000);
		check(16'(clr_n), 16'h0001);
		check(16'(wr_n), 16'h0000);
		run(OP_WR_BYTE, 8'hd1, 16'h005c);
		check({8'h00, wrd[7:0]}, 16'h005c);
		check(16'(wcnt), 16'h0001);
		run(OP_WR_WORD, 8'h21, 16'ha55a);
		check(wrd, 16'ha55a);
		check(16'(wcnt), 16'h0002);
		run(OP_RD_BYTE, 8'h8c, 16'h0000);
		check(hrd, 16'h008c);
		run(OP_RD_WORD, 8'hdd, 16'h0000);
		check(hrd, 16'h87dd);
		run(OP_RD_WORD, 8'h00, 16'h0000);
		check(hrd, 16'h5a00);
		check(16'(ptr_n), 16'h0006);
		check(16'(wr_n + clr_n), 16'h0003);
		finish_test;
	end
	initial begin
		repeat (100000) @(posedge clk);
		bad_count++;
		finish_test;
	end
endmodule : serial_command_slave_port_tb

// [src/scsp_bus_if.sv]
/*
 * Two-wire bus between the host end and the device end.
 * Assumes pull-ups on both wires: a wire is low while any enabled driver
 * drives low. The clock wire is driven by the host only.
 */
`timescale 1ns/100ps
interface scsp_bus_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	assign scl = host_scl_oe ? host_scl_o : 1'b1;
	assign sda = (host_sda_oe ? host_sda_o : 1'b1) &
	             (dev_sda_oe ? dev_sda_o : 1'b1);

	modport host (
		output host_scl_o,
		output host_scl_oe,
		output host_sda_o,
		output host_sda_oe,
		input  scl,
		input  sda
	);

	modport dev (
		output dev_sda_o,
		output dev_sda_oe,
		input  scl,
		input  sda
	);
endinterface : scsp_bus_if

// [src/scsp_device.sv]
/*
 * Device end of the serial command slave port. Link logic runs on the
 * link clock and decodes frames; register events cross to the system
 * clock by a toggle handshake, and read data comes back the same way.
 * Assumes the user answers RD_DATA_IN for CMD_OUT one edge after the
 * event pulse, and that bytes are far longer than the handshake.
 */
`timescale 1ns/100ps

// Behaviour
// RULE_01: Host waits supply valid over 2 ms
// RULE_02: Byte is eight bits plus acknowledge
// RULE_03: Data changes only while clock low
// RULE_04: Write ends with stop on tenth pulse
// RULE_05: Read ends with no-ack, then stop
// RULE_06: Direction fixed at operation start
// RULE_07: Accept up to three write bytes
// RULE_08: First byte after address sets pointer
// RULE_09: Write data goes to pointed register
// RULE_10: Byte read: pointer, restart, read address
// RULE_11: Host writes pointer before every access
// RULE_12: Send byte clears latched fault status
// RULE_13: Send byte: address, command, stop
// RULE_14: Write byte: address, command, data, stop
// RULE_15: Restart after final ack is accepted
// RULE_16: Support byte and word reads, writes
// RULE_17: Device acts only as bus slave
// RULE_18: Word read returns low byte first
// RULE_19: Foreign address: release data, ignore
module scsp_device #(
	parameter logic [6:0] DEV_ADDR = scsp_pkg::DEV_ADDR_DFLT
) (
	// System side clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        RESETN_IN,
	// Link clock and reset
	input  wire logic        LINK_CLK_IN,
	input  wire logic        LINK_RESETN_IN,
	// Register events
	output logic [7:0]       CMD_OUT,
	output logic             PTR_SET_OUT,
	output logic             WR_STB_OUT,
	output logic [15:0]      WR_DATA_OUT,
	output logic [1:0]       WR_COUNT_OUT,
	output logic             CLR_FAULT_OUT,
	// Read data for CMD_OUT
	input  wire logic [15:0] RD_DATA_IN,
	// Bus
	scsp_bus_if.dev          BUS
);
	import scsp_pkg::*;

	typedef enum logic [3:0] {
		D_IDLE   = 4'b0000,
		D_ADDR   = 4'b0001,
		D_ACK_A  = 4'b0010,
		D_CMD    = 4'b0011,
		D_ACK_C  = 4'b0100,
		D_WDATA  = 4'b0101,
		D_ACK_W  = 4'b0110,
		D_RDATA  = 4'b0111,
		D_RACK   = 4'b1000,
		D_IGNORE = 4'b1001
	} scsp_dst_type;

	// ------------------------------------------------------------------
	// Link domain: pin and handshake synchronisers
	// ------------------------------------------------------------------
	logic [2:0]   ls1_r;
	logic [2:0]   ls2_r;
	logic [2:0]   ls3_r;
	logic [2:0]   lf_r;
	logic [2:0]   ld_r;
	logic         scl_f;
	logic         sda_f;
	logic         rise_w;
	logic         fall_w;
	logic         start_w;
	logic         stop_w;
	logic         ack_new_w;
	logic         ack_tgl_r;

	always_ff @(posedge LINK_CLK_IN) begin
		if (!LINK_RESETN_IN) begin
			ls1_r <= 3'h3;
			ls2_r <= 3'h3;
			ls3_r <= 3'h3;
			lf_r  <= 3'h3;
			ld_r  <= 3'h3;
		end else begin
			ls1_r <= {ack_tgl_r, BUS.sda, BUS.scl};
			ls2_r <= ls1_r;
			ls3_r <= ls2_r;
			// A change counts only once stages two and three agree
			lf_r  <= (ls2_r & ls3_r) | (lf_r & (ls2_r ^ ls3_r));
			ld_r  <= lf_r;
		end
	end

	assign scl_f     = lf_r[0];
	assign sda_f     = lf_r[1];
	assign rise_w    = scl_f & ~ld_r[0];
	assign fall_w    = ~scl_f & ld_r[0];
	assign start_w   = scl_f & ld_r[0] & ~sda_f & ld_r[1]; // RULE_03
	assign stop_w    = scl_f & ld_r[0] & sda_f & ~ld_r[1]; // RULE_03
	assign ack_new_w = lf_r[2] ^ ld_r[2];

	// ------------------------------------------------------------------
	// Link domain: frame decoder
	// ------------------------------------------------------------------
	scsp_dst_type st_r;
	logic [3:0]   bit_cnt_r;
	logic [7:0]   shift_r;
	logic [7:0]   tx_r;
	logic         sda_oe_r;
	logic         dir_r;
	logic         cmd_ok_r;
	logic [1:0]   wcnt_r;
	logic [15:0]  wdata_r;
	logic         hi_sel_r;
	logic         mack_r;
	logic [15:0]  rd_word_r;
	logic [7:0]   nxt_tx_w;

	assign nxt_tx_w = hi_sel_r ? rd_word_r[15:8] : RD_PAD_BYTE; // RULE_18

	// Slave only: the clock wire is never driven from this end
	always_ff @(posedge LINK_CLK_IN) begin // RULE_17
		if (!LINK_RESETN_IN) begin
			st_r      <= D_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r   <= 8'h00;
			tx_r      <= 8'h00;
			sda_oe_r  <= 1'b0;
			dir_r     <= DIR_WRITE;
			cmd_ok_r  <= 1'b0;
			wcnt_r    <= 2'h0;
			wdata_r   <= 16'h0000;
			hi_sel_r  <= 1'b0;
			mack_r    <= 1'b0;
		end else if (start_w) begin // RULE_15
			st_r      <= D_ADDR;
			bit_cnt_r <= 4'h0;
			sda_oe_r  <= 1'b0;
			cmd_ok_r  <= 1'b0;
			wcnt_r    <= 2'h0;
		end else if (stop_w) begin
			st_r     <= D_IDLE;
			sda_oe_r <= 1'b0;
			cmd_ok_r <= 1'b0;
		end else if (rise_w) begin
			if (st_r == D_ADDR || st_r == D_CMD || st_r == D_WDATA) begin
				shift_r   <= {shift_r[6:0], sda_f};
				bit_cnt_r <= bit_cnt_r + 4'h1; // RULE_02
			end else if (st_r == D_RDATA) begin
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end else if (st_r == D_RACK) begin
				mack_r <= ~sda_f;
			end
		end else if (fall_w) begin
			unique case (st_r)
				D_ADDR: if (bit_cnt_r == BIT_LAST) begin
					if (shift_r[7:1] == DEV_ADDR) begin
						sda_oe_r <= 1'b1;
						dir_r    <= shift_r[0]; // RULE_06
						st_r     <= D_ACK_A;
					end else begin
						st_r <= D_IGNORE; // RULE_19
					end
				end
				D_ACK_A: begin
					bit_cnt_r <= 4'h0;
					if (dir_r == DIR_READ) begin // RULE_10
						tx_r     <= rd_word_r[7:0];
						hi_sel_r <= 1'b1;
						sda_oe_r <= ~rd_word_r[7];
						st_r     <= D_RDATA;
					end else begin
						sda_oe_r <= 1'b0;
						st_r     <= D_CMD;
					end
				end
				D_CMD: if (bit_cnt_r == BIT_LAST) begin // RULE_08
					cmd_ok_r <= 1'b1;
					sda_oe_r <= 1'b1;
					st_r     <= D_ACK_C;
				end
				D_ACK_C, D_ACK_W: begin
					sda_oe_r  <= 1'b0;
					bit_cnt_r <= 4'h0;
					st_r      <= D_WDATA;
				end
				D_WDATA: if (bit_cnt_r == BIT_LAST) begin
					// Command plus at most two data bytes
					if (wcnt_r < MAX_WR_DATA) begin // RULE_07
						if (wcnt_r == 2'h0)
							wdata_r[7:0] <= shift_r; // RULE_09
						else
							wdata_r[15:8] <= shift_r;
						wcnt_r   <= wcnt_r + 2'h1;
						sda_oe_r <= 1'b1;
						st_r     <= D_ACK_W;
					end else begin
						st_r <= D_IGNORE;
					end
				end
				D_RDATA: if (bit_cnt_r == BIT_LAST) begin
					sda_oe_r <= 1'b0;
					st_r     <= D_RACK;
				end else begin
					sda_oe_r <= ~tx_r[BIT_MSB - bit_cnt_r[2:0]]; // RULE_03
				end
				D_RACK: begin
					bit_cnt_r <= 4'h0;
					if (mack_r) begin // RULE_18
						tx_r     <= nxt_tx_w;
						hi_sel_r <= 1'b0;
						sda_oe_r <= ~nxt_tx_w[7];
						st_r     <= D_RDATA;
					end else begin
						st_r <= D_IGNORE; // RULE_05
					end
				end
				D_IDLE, D_IGNORE: begin
				end
			endcase
		end
	end

	assign BUS.dev_sda_oe = sda_oe_r;
	assign BUS.dev_sda_o  = OD_LOW;

	// ------------------------------------------------------------------
	// Link domain: event launch and read data return
	// ------------------------------------------------------------------
	logic         ev_req_r;
	scsp_ev_type  ev_kind_r;
	logic [7:0]   ev_cmd_r;
	logic [15:0]  ev_data_r;
	logic [1:0]   ev_cnt_r;
	logic [15:0]  rd_hold_r;
	logic         cmd_ev_w;
	logic         end_ev_w;

	assign cmd_ev_w = fall_w && st_r == D_CMD && bit_cnt_r == BIT_LAST;
	assign end_ev_w = stop_w && cmd_ok_r && dir_r == DIR_WRITE; // RULE_13

	// Payload is held until the next toggle, so it is stable when sampled
	always_ff @(posedge LINK_CLK_IN) begin
		if (!LINK_RESETN_IN) begin
			ev_req_r  <= 1'b0;
			ev_kind_r <= EV_PTR;
			ev_cmd_r  <= 8'h00;
			ev_data_r <= 16'h0000;
			ev_cnt_r  <= 2'h0;
		end else if (cmd_ev_w) begin
			ev_req_r  <= ~ev_req_r;
			ev_kind_r <= EV_PTR; // RULE_08
			ev_cmd_r  <= shift_r;
		end else if (end_ev_w) begin
			ev_req_r  <= ~ev_req_r;
			// Command with no data is the fault clear
			ev_kind_r <= (wcnt_r == 2'h0) ? EV_CLEAR : EV_WRITE; // RULE_12
			ev_data_r <= wdata_r; // RULE_14
			ev_cnt_r  <= wcnt_r;
		end
	end

	always_ff @(posedge LINK_CLK_IN) begin
		if (!LINK_RESETN_IN)
			rd_word_r <= 16'h0000;
		else if (ack_new_w)
			rd_word_r <= rd_hold_r;
	end

	// ------------------------------------------------------------------
	// System domain: event receive, read data sample, acknowledge
	// ------------------------------------------------------------------
	logic [2:0]   rq_s_r;
	logic         rq_f_r;
	logic         rq_d_r;
	logic         rq_new_w;
	logic [RD_SAMPLE_DLY-1:0] pend_r;

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			rq_s_r <= 3'h0;
			rq_f_r <= 1'b0;
			rq_d_r <= 1'b0;
		end else begin
			rq_s_r <= {rq_s_r[1:0], ev_req_r};
			if (rq_s_r[1] == rq_s_r[2])
				rq_f_r <= rq_s_r[2];
			rq_d_r <= rq_f_r;
		end
	end

	assign rq_new_w = rq_f_r ^ rq_d_r;

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			CMD_OUT       <= 8'h00;
			PTR_SET_OUT   <= 1'b0;
			WR_STB_OUT    <= 1'b0;
			WR_DATA_OUT   <= 16'h0000;
			WR_COUNT_OUT  <= 2'h0;
			CLR_FAULT_OUT <= 1'b0;
		end else begin
			PTR_SET_OUT   <= rq_new_w && ev_kind_r == EV_PTR;
			WR_STB_OUT    <= rq_new_w && ev_kind_r == EV_WRITE;
			CLR_FAULT_OUT <= rq_new_w && ev_kind_r == EV_CLEAR; // RULE_12
			if (rq_new_w && ev_kind_r == EV_PTR)
				CMD_OUT <= ev_cmd_r;
			if (rq_new_w && ev_kind_r == EV_WRITE) begin
				WR_DATA_OUT  <= ev_data_r; // RULE_09
				WR_COUNT_OUT <= ev_cnt_r; // RULE_16
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			pend_r    <= '0;
			rd_hold_r <= 16'h0000;
			ack_tgl_r <= 1'b0;
		end else begin
			pend_r <= {pend_r[RD_SAMPLE_DLY-2:0], rq_new_w};
			if (pend_r[RD_SAMPLE_DLY-1]) begin
				rd_hold_r <= RD_DATA_IN;
				ack_tgl_r <= ~ack_tgl_r;
			end
		end
	end

endmodule : scsp_device

// [src/scsp_host.sv]
/*
 * Host end: bus master that runs send byte, write byte, write word,
 * read byte and read word operations. The bus clock is made here by a
 * divider from the system clock. Assumes one operation at a time and a
 * device whose link clock is much faster than a quarter bus period.
 */
`timescale 1ns/100ps
module scsp_host #(
	parameter logic [6:0]  DEV_ADDR    = scsp_pkg::DEV_ADDR_DFLT,
	parameter int unsigned SCL_QTR     = scsp_pkg::SCL_QTR_DFLT,
	parameter int unsigned SUPPLY_WAIT = scsp_pkg::SUPPLY_WAIT_CYC
) (
	// Clock and reset
	input  wire logic                 CLK_IN,
	input  wire logic                 RESETN_IN,
	// Supply status
	input  wire logic                 MAIN_SUPPLY_RAIL_OK_IN,
	// Command port
	input  wire logic                 CMD_VALID_IN,
	input  wire scsp_pkg::scsp_op_type CMD_OP_IN,
	input  wire logic [7:0]           CMD_CODE_IN,
	input  wire logic [15:0]          CMD_DATA_IN,
	output logic                      CMD_READY_OUT,
	// Completion
	output logic                      DONE_OUT,
	output logic                      ACK_ERR_OUT,
	output logic [15:0]               RD_DATA_OUT,
	// Bus
	scsp_bus_if.host                  BUS
);
	import scsp_pkg::*;

	localparam int unsigned PW_W = $clog2(SUPPLY_WAIT + 1);
	localparam int unsigned QW   = $clog2(SCL_QTR + 1);

	typedef enum logic {
		H_IDLE = 1'b0,
		H_RUN  = 1'b1
	} scsp_hst_type;

	// Every operation opens by writing the pointer
	function automatic scsp_step_type step_f(scsp_op_type op,
		logic [3:0] idx, logic [7:0] code, logic [15:0] data);
		scsp_step_type s;
		s.kind = K_STOP;
		s.data = 8'h00;
		unique case (idx)
			4'h0: s.kind = K_START;
			4'h1: s = '{K_WR, {DEV_ADDR, DIR_WRITE}};
			4'h2: s = '{K_WR, code};
			default: begin
				unique case (op)
					OP_WR_BYTE: if (idx == 4'h3) s = '{K_WR, data[7:0]};
					OP_WR_WORD: if (idx == 4'h3) s = '{K_WR, data[7:0]};
						else if (idx == 4'h4) s = '{K_WR, data[15:8]};
					OP_RD_BYTE, OP_RD_WORD: begin
						if (idx == 4'h3)
							s.kind = K_START;
						else if (idx == 4'h4)
							s = '{K_WR, {DEV_ADDR, DIR_READ}};
						else if (idx == 4'h5)
							s.kind = (op == OP_RD_WORD) ? K_RDA : K_RDN;
						else if (idx == 4'h6 && op == OP_RD_WORD)
							s.kind = K_RDN;
					end
					default: s.kind = K_STOP;
				endcase
			end
		endcase
		return s;
	endfunction : step_f

	// ------------------------------------------------------------------
	// Input synchronisers and supply wait
	// ------------------------------------------------------------------
	logic [1:0]   s1_r;
	logic [1:0]   s2_r;
	logic [1:0]   s3_r;
	logic [1:0]   f_r;
	logic [PW_W-1:0] pwr_cnt_r;
	logic         pwr_ok_r;

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			s1_r <= 2'h1;
			s2_r <= 2'h1;
			s3_r <= 2'h1;
			f_r  <= 2'h1;
		end else begin
			s1_r <= {MAIN_SUPPLY_RAIL_OK_IN, BUS.sda};
			s2_r <= s1_r;
			s3_r <= s2_r;
			f_r  <= (s2_r & s3_r) | (f_r & (s2_r ^ s3_r));
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			pwr_cnt_r <= '0;
			pwr_ok_r  <= 1'b0;
		end else begin
			if (!f_r[1])
				pwr_cnt_r <= '0;
			else if (pwr_cnt_r != PW_W'(SUPPLY_WAIT))
				pwr_cnt_r <= pwr_cnt_r + 1'b1;
			pwr_ok_r <= f_r[1] && pwr_cnt_r == PW_W'(SUPPLY_WAIT); // RULE_01
		end
	end

	// ------------------------------------------------------------------
	// Quarter-period divider for the bus clock
	// ------------------------------------------------------------------
	logic [QW-1:0] div_r;
	logic          tick_w;

	assign tick_w = div_r == QW'(SCL_QTR - 1);

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN || tick_w)
			div_r <= '0;
		else
			div_r <= div_r + 1'b1;
	end

	// ------------------------------------------------------------------
	// Operation sequencer and bit engine
	// ------------------------------------------------------------------
	scsp_hst_type  st_r;
	scsp_op_type   op_r;
	logic [7:0]    code_r;
	logic [15:0]   data_r;
	logic [3:0]    step_r;
	logic [1:0]    q_r;
	logic [3:0]    bit_r;
	logic [7:0]    rx_r;
	logic [7:0]    lo_r;
	logic          nack_r;
	logic          abort_r;
	logic          scl_oe_r;
	logic          sda_oe_r;
	scsp_step_type cur_w;
	scsp_kind_type kind_w;
	logic          drv_w;

	assign cur_w  = step_f(op_r, step_r, code_r, data_r);
	assign kind_w = abort_r ? K_STOP : cur_w.kind;
	assign drv_w  = (kind_w == K_WR) ?
		(bit_r != BIT_LAST && !cur_w.data[BIT_MSB - bit_r[2:0]]) :
		(bit_r == BIT_LAST && kind_w == K_RDA);

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			st_r          <= H_IDLE;
			op_r          <= OP_SEND;
			code_r        <= 8'h00;
			data_r        <= 16'h0000;
			step_r        <= 4'h0;
			q_r           <= 2'h0;
			bit_r         <= 4'h0;
			rx_r          <= 8'h00;
			lo_r          <= 8'h00;
			nack_r        <= 1'b0;
			abort_r       <= 1'b0;
			scl_oe_r      <= 1'b0;
			sda_oe_r      <= 1'b0;
			CMD_READY_OUT <= 1'b0;
			DONE_OUT      <= 1'b0;
			ACK_ERR_OUT   <= 1'b0;
			RD_DATA_OUT   <= 16'h0000;
		end else begin
			DONE_OUT <= 1'b0;
			if (st_r == H_IDLE) begin
				if (CMD_VALID_IN && CMD_READY_OUT) begin // RULE_11
					st_r          <= H_RUN;
					op_r          <= CMD_OP_IN;
					code_r        <= CMD_CODE_IN;
					data_r        <= CMD_DATA_IN;
					step_r        <= 4'h0;
					q_r           <= 2'h0;
					bit_r         <= 4'h0;
					abort_r       <= 1'b0;
					CMD_READY_OUT <= 1'b0;
				end else begin
					CMD_READY_OUT <= pwr_ok_r; // RULE_01
				end
			end else if (tick_w) begin
				q_r <= q_r + 2'h1;
				unique case (kind_w)
					K_START: begin // RULE_10
						if (q_r == 2'h0) sda_oe_r <= 1'b0;
						if (q_r == 2'h1) scl_oe_r <= 1'b0;
						if (q_r == 2'h2) sda_oe_r <= 1'b1;
						if (q_r == 2'h3) begin
							scl_oe_r <= 1'b1;
							step_r   <= step_r + 4'h1;
						end
					end
					K_STOP: begin // RULE_04
						if (q_r == 2'h0) sda_oe_r <= 1'b1;
						if (q_r == 2'h1) scl_oe_r <= 1'b0;
						if (q_r == 2'h2) sda_oe_r <= 1'b0;
						if (q_r == 2'h3) begin
							st_r        <= H_IDLE;
							DONE_OUT    <= 1'b1;
							ACK_ERR_OUT <= abort_r;
						end
					end
					default: begin
						// Data moves only while the clock is low
						if (q_r == 2'h0) sda_oe_r <= drv_w; // RULE_03
						if (q_r == 2'h1) scl_oe_r <= 1'b0;
						if (q_r == 2'h2) begin
							if (bit_r == BIT_LAST)
								nack_r <= f_r[0];
							else
								rx_r <= {rx_r[6:0], f_r[0]};
						end
						if (q_r == 2'h3) begin
							scl_oe_r <= 1'b1;
							if (bit_r == BIT_LAST) begin // RULE_02
								bit_r  <= 4'h0;
								step_r <= step_r + 4'h1;
								if (kind_w == K_WR && nack_r)
									abort_r <= 1'b1;
								if (kind_w == K_RDA)
									lo_r <= rx_r;
								if (kind_w == K_RDN) begin // RULE_05
									RD_DATA_OUT <= (op_r == OP_RD_WORD) ?
										{rx_r, lo_r} : {8'h00, rx_r};
								end
							end else begin
								bit_r <= bit_r + 4'h1;
							end
						end
					end
				endcase
			end
		end
	end

	assign BUS.host_scl_oe = scl_oe_r;
	assign BUS.host_scl_o  = OD_LOW;
	assign BUS.host_sda_oe = sda_oe_r;
	assign BUS.host_sda_o  = OD_LOW;

endmodule : scsp_host

// [src/scsp_pkg.sv]
/*
 * Shared constants and types of the two-wire serial command slave port:
 * timing, bus addressing, operation codes, event kinds and host step kinds.
 * Assumes a 250 MHz system clock on both ends.
 */
package scsp_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS   = 4000;
	localparam int unsigned SUPPLY_WAIT_MS  = 2;
	// Strictly more than the wait, so one cycle beyond the rounded-up count
	localparam longint unsigned SUPPLY_WAIT_PS =
		longint'(SUPPLY_WAIT_MS) * 64'd1000000000;
	localparam int unsigned SUPPLY_WAIT_CYC =
		int'((SUPPLY_WAIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) + 1;
	// Quarter of a bus clock period, in system clocks
	localparam int unsigned SCL_QTR_DFLT    = 100;
	// Edges from the event edge to the read-data sample
	localparam int unsigned RD_SAMPLE_DLY   = 2;

	// ------------------------------------------------------------------
	// Framing and addressing
	// ------------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR_DFLT  = 7'h20;
	localparam logic [3:0] BIT_LAST       = 4'h8;
	localparam logic [2:0] BIT_MSB        = 3'h7;
	localparam logic [1:0] MAX_WR_DATA    = 2'h2;
	localparam logic [7:0] RD_PAD_BYTE    = 8'hff;
	localparam logic       DIR_WRITE      = 1'b0;
	localparam logic       DIR_READ       = 1'b1;
	localparam logic       OD_LOW         = 1'b0;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_SEND    = 3'b000,
		OP_WR_BYTE = 3'b001,
		OP_WR_WORD = 3'b010,
		OP_RD_BYTE = 3'b011,
		OP_RD_WORD = 3'b100
	} scsp_op_type;

	typedef enum logic [1:0] {
		EV_PTR   = 2'b00,
		EV_WRITE = 2'b01,
		EV_CLEAR = 2'b10
	} scsp_ev_type;

	typedef enum logic [2:0] {
		K_START = 3'b000,
		K_WR    = 3'b001,
		K_RDA   = 3'b010,
		K_RDN   = 3'b011,
		K_STOP  = 3'b100
	} scsp_kind_type;

	typedef struct packed {
		scsp_kind_type kind;
		logic [7:0]    data;
	} scsp_step_type;

endpackage : scsp_pkg
